// file: hdl/vims_top.sv
// Purpose: VGA input mode recognition, sampling clock choice and panel mapping.
// Assumes: All inputs synchronous to MCLK; pixels arrive with PIX_VALID.
// Notes: Mode, switch and row origin change only at the start of a frame.
//
// Summary of operation
// RQ1 - Accept sync of either polarity, progressive
// RQ2 - Recognise 640x480 at 31.469k/60Hz, 25.175MHz
// RQ3 - Recognise 640x400 at 24.827k/56Hz, 21.053MHz
// RQ4 - Recognise 640 wide 70Hz modes, 25.175MHz
// RQ5 - Recognise 720 wide 70Hz modes, 28.322MHz
// RQ6 - Switch picks handling of 720 lines
// RQ7 - Text mode keeps first 640, drops 80
// RQ8 - Graphics mode resamples 720 onto 640
// RQ9 - 350 lines padded 50 to 400, scaled 1.2
// RQ10 - One switch input selects display mode
// RQ11 - Switch off text, on graphics only
// RQ12 - 400 and 350 line pictures centred
// RQ13 - Match periods to table, split shared rates
`default_nettype none
`include "vims_params.svh"
module vims_top
	import vims_pkg::*;
#(
	parameter int P_CLK_HZ = `VIMS_CLK_HZ,
	parameter int PIX_W = 18,
	parameter int CNT_W = 22
) (
	input wire logic MCLK,
	input wire logic RST_B,
	input wire logic HSYNC,
	input wire logic VSYNC,
	input wire logic DISPLAY_MODE_SWITCH,
	input wire logic WIDE_SRC,
	input wire logic PIX_VALID,
	input wire logic [PIX_W-1:0] PIX_DATA,
	output vims_mode_t MODE,
	output logic MODE_LOCK,
	output logic GFX_ONLY,
	output logic [9:0] PLL_DIV,
	output logic OUT_VALID,
	output logic [PIX_W-1:0] OUT_DATA,
	output logic [9:0] OUT_COL,
	output logic [8:0] OUT_ROW,
	output logic [1:0] OUT_ROW_CNT
);
	// ****************************************
	// Derived counts
	// ****************************************
	localparam int LA_LO = P_CLK_HZ / (`VIMS_LINE_A_HZ + `VIMS_LINE_TOL_HZ);
	localparam int LA_HI = P_CLK_HZ / (`VIMS_LINE_A_HZ - `VIMS_LINE_TOL_HZ);
	localparam int LB_LO = P_CLK_HZ / (`VIMS_LINE_B_HZ + `VIMS_LINE_TOL_HZ);
	localparam int LB_HI = P_CLK_HZ / (`VIMS_LINE_B_HZ - `VIMS_LINE_TOL_HZ);
	localparam int F60_LO = P_CLK_HZ / (`VIMS_FRAME_60_HZ + `VIMS_FRAME_TOL_HZ);
	localparam int F60_HI = P_CLK_HZ / (`VIMS_FRAME_60_HZ - `VIMS_FRAME_TOL_HZ);
	localparam int F56_LO = P_CLK_HZ / (`VIMS_FRAME_56_HZ + `VIMS_FRAME_TOL_HZ);
	localparam int F56_HI = P_CLK_HZ / (`VIMS_FRAME_56_HZ - `VIMS_FRAME_TOL_HZ);
	localparam int F70_LO = P_CLK_HZ / (`VIMS_FRAME_70_HZ + `VIMS_FRAME_TOL_HZ);
	localparam int F70_HI = P_CLK_HZ / (`VIMS_FRAME_70_HZ - `VIMS_FRAME_TOL_HZ);
	// Sampling clock per line, rounded to the nearest whole dot
	localparam int DIV_A = (`VIMS_DOT_A_KHZ * 1000 + `VIMS_LINE_A_HZ / 2) / `VIMS_LINE_A_HZ;
	localparam int DIV_B = (`VIMS_DOT_B_KHZ * 1000 + `VIMS_LINE_B_HZ / 2) / `VIMS_LINE_B_HZ;
	localparam int DIV_C = (`VIMS_DOT_C_KHZ * 1000 + `VIMS_LINE_A_HZ / 2) / `VIMS_LINE_A_HZ;
	localparam logic [9:0] PLL_A = 10'(DIV_A);
	localparam logic [9:0] PLL_B = 10'(DIV_B);
	localparam logic [9:0] PLL_C = 10'(DIV_C);
	localparam logic [10:0] COLS = 11'(`VIMS_PANEL_COLS);
	localparam logic [3:0] PH9_LAST = 4'(`VIMS_DECIM_PERIOD - 1);
	localparam logic [2:0] PH5_LAST = 3'(`VIMS_SCALE_DEN - 1);
	// Pad lines split evenly above and below, else the scaled picture sits low
	localparam logic [8:0] PAD_ROWS = 9'(`VIMS_PAD_LINES / 2 * `VIMS_SCALE_NUM / `VIMS_SCALE_DEN);

	typedef struct packed {
		vims_mode_t mode;
		logic gfx;
		logic [9:0] pll_div;
		logic h_prev;
		logic v_prev;
		logic [10:0] col_in;
		logic [3:0] ph9;
		logic [9:0] col_out;
		logic [8:0] row;
		logic [2:0] ph5;
		logic [1:0] rcnt;
		logic seen;
		logic ovalid;
		logic [PIX_W-1:0] odata;
		logic [9:0] ocol;
	} vims_top_state_t;

	vims_top_state_t st_reg;
	vims_top_state_t st_next;
	logic [CNT_W-1:0] h_per;
	logic [CNT_W-1:0] v_per;
	logic v_act_hi;
	logic h_sync;
	logic v_sync;
	logic ha, hb, v60, v56, v70;
	logic frame_start, line_start, is720, scaled, keep;
	vims_mode_t det;
	logic [9:0] det_div;

	// ****************************************
	// Sync measurement
	// ****************************************
	vims_period_meter #(.CNT_W(CNT_W)) u_hmeter (
		.clk(MCLK),
		.rst_b(RST_B),
		.sig(HSYNC),
		.period(h_per),
		.act_hi(),
		.sync_act(h_sync)
	);

	vims_period_meter #(.CNT_W(CNT_W)) u_vmeter (
		.clk(MCLK),
		.rst_b(RST_B),
		.sig(VSYNC),
		.period(v_per),
		.act_hi(v_act_hi),
		.sync_act(v_sync)
	);

	// ****************************************
	// Mode classification
	// ****************************************
	// RQ13 - period window match
	always_comb begin
		ha = h_per >= CNT_W'(LA_LO) && h_per <= CNT_W'(LA_HI);
		hb = h_per >= CNT_W'(LB_LO) && h_per <= CNT_W'(LB_HI);
		v60 = v_per >= CNT_W'(F60_LO) && v_per <= CNT_W'(F60_HI);
		v56 = v_per >= CNT_W'(F56_LO) && v_per <= CNT_W'(F56_HI);
		v70 = v_per >= CNT_W'(F70_LO) && v_per <= CNT_W'(F70_HI);
	end

	// Shared 70 Hz rate is split by width hint and vertical sync polarity
	always_comb begin
		det = VIMS_NONE;
		det_div = PLL_A;
		// RQ2 - 640x480 recognition
		if (ha && v60) begin
			det = VIMS_640X480_60;
		end
		// RQ3 - 56 Hz recognition
		else if (hb && v56) begin
			det = VIMS_640X400_56;
			det_div = PLL_B;
		end
		// RQ13 - width and polarity split
		else if (ha && v70) begin
			// RQ5 - 720 wide clock
			if (WIDE_SRC) begin
				det = v_act_hi ? VIMS_720X400_70 : VIMS_720X350_70;
				det_div = PLL_C;
			end
			// RQ4 - 640 wide 70Hz
			else begin
				det = v_act_hi ? VIMS_640X400_70 : VIMS_640X350_70;
			end
		end
	end

	// ****************************************
	// Pixel and line mapping
	// ****************************************
	assign frame_start = v_sync && !st_reg.v_prev;
	assign line_start = h_sync && !st_reg.h_prev;
	assign is720 = st_reg.mode == VIMS_720X400_70 || st_reg.mode == VIMS_720X350_70;
	assign scaled = st_reg.mode != VIMS_640X480_60 && st_reg.mode != VIMS_NONE;

	// RQ6 - switch picks handling
	always_comb begin
		// RQ7 - crop to 640
		if (!is720 || !st_reg.gfx)
			keep = st_reg.col_in < COLS;
		// RQ8 - drop one in nine
		else
			keep = st_reg.ph9 != PH9_LAST;
	end

	always_comb begin
		st_next = st_reg;
		st_next.h_prev = h_sync;
		st_next.v_prev = v_sync;
		st_next.ovalid = 1'b0;
		if (frame_start) begin
			st_next.mode = det;
			st_next.pll_div = det_div;
			// RQ10 - single switch input
			// RQ11 - off text, on graphics
			st_next.gfx = DISPLAY_MODE_SWITCH;
			// RQ12 - centred via padding
			// RQ9 - 50 line pad
			st_next.row = (det == VIMS_640X350_70 || det == VIMS_720X350_70) ? PAD_ROWS : 9'h000;
			st_next.ph5 = 3'h0;
			st_next.rcnt = 2'h1;
			st_next.seen = 1'b0;
		end
		else if (line_start) begin
			st_next.col_in = 11'h000;
			st_next.ph9 = 4'h0;
			st_next.col_out = 10'h000;
			if (st_reg.seen) begin
				st_next.row = st_reg.row + {7'h00, st_reg.rcnt};
				st_next.ph5 = (st_reg.ph5 == PH5_LAST) ? 3'h0 : st_reg.ph5 + 3'h1;
				// RQ9 - 1.2 vertical scale
				st_next.rcnt = (scaled && st_next.ph5 == PH5_LAST) ? 2'h2 : 2'h1;
			end
			st_next.seen = 1'b0;
		end
		else if (PIX_VALID) begin
			st_next.seen = 1'b1;
			if (st_reg.col_in != 11'h7ff)
				st_next.col_in = st_reg.col_in + 11'h001;
			st_next.ph9 = (st_reg.ph9 == PH9_LAST) ? 4'h0 : st_reg.ph9 + 4'h1;
			if (keep && {1'b0, st_reg.col_out} < COLS) begin
				st_next.ovalid = 1'b1;
				st_next.odata = PIX_DATA;
				st_next.ocol = st_reg.col_out;
				st_next.col_out = st_reg.col_out + 10'h001;
			end
		end
	end

	always_ff @(posedge MCLK) begin
		if (!RST_B)
			st_reg <= '0;
		else
			st_reg <= st_next;
	end

	// Outputs straight from the state register; MODE_LOCK is decoded from the registered mode
	assign MODE = st_reg.mode;
	assign MODE_LOCK = st_reg.mode != VIMS_NONE;
	assign GFX_ONLY = st_reg.gfx;
	assign PLL_DIV = st_reg.pll_div;
	assign OUT_VALID = st_reg.ovalid;
	assign OUT_DATA = st_reg.odata;
	assign OUT_COL = st_reg.ocol;
	assign OUT_ROW = st_reg.row;
	assign OUT_ROW_CNT = st_reg.rcnt;

	// ****************************************
	// Checks
	// ****************************************
	a_vga480_lock: assert property (@(posedge MCLK) disable iff (!RST_B) // RQ2
		(frame_start && ha && v60) |=> (MODE == VIMS_640X480_60 && PLL_DIV == PLL_A && MODE_LOCK))
		else $error("640x480 not recognised");
	a_rate56_lock: assert property (@(posedge MCLK) disable iff (!RST_B) // RQ3
		(frame_start && hb && v56) |=> (MODE == VIMS_640X400_56 && PLL_DIV == PLL_B))
		else $error("56 Hz mode not recognised");
	a_narrow70_clk: assert property (@(posedge MCLK) disable iff (!RST_B) // RQ4
		(frame_start && ha && v70 && !WIDE_SRC) |=> (PLL_DIV == PLL_A && !is720))
		else $error("640 wide 70 Hz mode wrong");
	a_wide70_clk: assert property (@(posedge MCLK) disable iff (!RST_B) // RQ5
		(frame_start && ha && v70 && WIDE_SRC) |=> (PLL_DIV == PLL_C && is720))
		else $error("720 wide mode wrong");
	a_text_crop: assert property (@(posedge MCLK) disable iff (!RST_B) // RQ7
		(PIX_VALID && !frame_start && !line_start && is720 && !st_reg.gfx && st_reg.col_in >= COLS)
		|=> !OUT_VALID)
		else $error("pixel past 640 shown in text mode");
	a_gfx_decim: assert property (@(posedge MCLK) disable iff (!RST_B) // RQ8
		(PIX_VALID && !frame_start && !line_start && is720 && st_reg.gfx && st_reg.ph9 == PH9_LAST)
		|=> !OUT_VALID)
		else $error("ninth pixel not dropped");
	a_switch_take: assert property (@(posedge MCLK) disable iff (!RST_B) // RQ11
		frame_start |=> (GFX_ONLY == $past(DISPLAY_MODE_SWITCH)))
		else $error("display mode switch not taken");
	a_pad_centre: assert property (@(posedge MCLK) disable iff (!RST_B) // RQ12
		(frame_start && (det == VIMS_640X350_70 || det == VIMS_720X350_70)) |=> (OUT_ROW == PAD_ROWS))
		else $error("350 line picture not centred");
	a_row_step: assert property (@(posedge MCLK) disable iff (!RST_B) // RQ9
		(line_start && !frame_start && st_reg.seen) |=> (OUT_ROW == $past(OUT_ROW) + {7'h00, $past(OUT_ROW_CNT)}))
		else $error("panel row did not advance");
endmodule : vims_top
`default_nettype wire

// file: inc/vims_params.svh
// Purpose: Timing figures and geometry constants for the VGA input scaler.
// Assumes: Included by the design files only.
// Notes: Line and frame rates are in hertz, sampling clocks in kHz; cycle counts are derived in the modules.
`ifndef VIMS_PARAMS_SVH
`define VIMS_PARAMS_SVH
// Local clock rate
`define VIMS_CLK_HZ 200000000
// Line rates and tolerance, in Hz
`define VIMS_LINE_A_HZ 31469
`define VIMS_LINE_B_HZ 24827
`define VIMS_LINE_TOL_HZ 1000
// Frame rates and tolerance, in Hz
`define VIMS_FRAME_60_HZ 60
`define VIMS_FRAME_56_HZ 56
`define VIMS_FRAME_70_HZ 70
`define VIMS_FRAME_TOL_HZ 1
// Sampling clocks, in kHz
`define VIMS_DOT_A_KHZ 25175
`define VIMS_DOT_B_KHZ 21053
`define VIMS_DOT_C_KHZ 28322
// Geometry
`define VIMS_PANEL_COLS 640
`define VIMS_DECIM_PERIOD 9
`define VIMS_PAD_LINES 50
`define VIMS_SCALE_NUM 6
`define VIMS_SCALE_DEN 5
`endif

// file: inc/vims_pkg.sv
// Purpose: Shared types of the VGA input scaler.
// Assumes: Compiled before the design modules.
// Notes: Mode codes carry no fixed encoding.
`default_nettype none
package vims_pkg;
	// Recognised input video modes
	typedef enum logic [2:0] {
		VIMS_NONE,
		VIMS_640X480_60,
		VIMS_640X400_56,
		VIMS_640X400_70,
		VIMS_640X350_70,
		VIMS_720X400_70,
		VIMS_720X350_70
	} vims_mode_t;
endpackage : vims_pkg
`default_nettype wire

// file: hdl/vims_period_meter.sv
// Purpose: Measures the period and active polarity of one sync input.
// Assumes: Sync is synchronous to clk; period far longer than its pulse.
// Notes: Active level is taken as the shorter of the two levels.
`default_nettype none
module vims_period_meter #(
	parameter int CNT_W = 22
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic sig,
	output logic [CNT_W-1:0] period,
	output logic act_hi,
	output logic sync_act
);
	typedef struct packed {
		logic prev;
		logic [CNT_W-1:0] cnt;
		logic [CNT_W-1:0] hi;
		logic [CNT_W-1:0] period;
		logic act_hi;
		logic sync_act;
	} vims_meter_state_t;

	vims_meter_state_t st_reg;
	vims_meter_state_t st_next;
	localparam logic [CNT_W-1:0] CNT_MAX = '1;

	// ****************************************
	// Period and polarity measurement
	// ****************************************
	// Counters saturate so a stalled sync never wraps into a valid period
	always_comb begin
		st_next = st_reg;
		st_next.prev = sig;
		if (st_reg.cnt != CNT_MAX)
			st_next.cnt = st_reg.cnt + 1'b1;
		if (sig && st_reg.hi != CNT_MAX)
			st_next.hi = st_reg.hi + 1'b1;
		if (sig && !st_reg.prev) begin
			st_next.period = st_reg.cnt;
			// RQ1 - either sync polarity
			st_next.act_hi = {st_reg.hi, 1'b0} < {1'b0, st_reg.cnt};
			st_next.cnt = {{(CNT_W-1){1'b0}}, 1'b1};
			st_next.hi = {{(CNT_W-1){1'b0}}, 1'b1};
		end
		st_next.sync_act = (sig == st_next.act_hi);
	end

	always_ff @(posedge clk) begin
		if (!rst_b)
			st_reg <= '0;
		else
			st_reg <= st_next;
	end

	assign period = st_reg.period;
	assign act_hi = st_reg.act_hi;
	assign sync_act = st_reg.sync_act;

	// Polarity follows the measured duty of the last period
	a_polarity_pick: assert property (@(posedge clk) disable iff (!rst_b) // RQ1
		(sig && !st_reg.prev) |=> (act_hi == ({$past(st_reg.hi), 1'b0} < {1'b0, $past(st_reg.cnt)})))
		else $error("sync polarity not taken from duty");
endmodule : vims_period_meter
`default_nettype wire

// file: verif/vims_vga_src.sv
// Purpose: Graphics adapter model, sync plus pixel bursts.
// Assumes: Controls change at clk rising edge.
// Notes: Lines and frames run from separate counters.
`default_nettype none
module vims_vga_src (
	input wire logic clk,
	input wire logic hpol,
	input wire logic vpol,
	input wire logic [13:0] frame_len,
	input wire logic [3:0] line_len,
	input wire logic [9:0] npix,
	input wire logic [3:0] nlines,
	input wire logic go,
	output logic hsync,
	output logic vsync,
	output logic pix_valid,
	output logic [17:0] pix_data,
	output logic busy,
	output logic frame_tick
);
	timeunit 1ns;
	timeprecision 100ps;
	int hc = 0;
	int vc = 0;
	int left = 0;
	int len = 6;
	int np = 0;
	// ************************
	// Scan generator
	// ************************
	// Long lines only while a burst's pixels plus three exceed line_len
	always @(posedge clk) begin
		hc = (hc + 1 >= len) ? 0 : hc + 1;
		vc = (vc + 1 >= int'(frame_len)) ? 0 : vc + 1;
		if (go && left == 0)
			left = int'(nlines);
		if (hc == 0) begin
			np = (left > 0) ? int'(npix) : 0;
			left = (left > 0) ? left - 1 : 0;
			len = (np + 3 > int'(line_len)) ? np + 3 : int'(line_len);
		end
		hsync <= (hc < 2) ? hpol : !hpol;
		vsync <= (vc < 32) ? vpol : !vpol;
		frame_tick <= (vc == 0);
		// Data changes every cycle, idle too
		pix_valid <= (hc >= 2) && (hc < 2 + np);
		pix_data <= 18'(hc - 2);
		busy <= (left > 0) || (np > 0);
	end
endmodule : vims_vga_src
`default_nettype wire

// file: verif/vga_input_mode_scaler_tb_top.sv
// Purpose: Self-checking bench of the input scaler.
// Assumes: Clock scaled to 200 kHz nominal to keep frames short.
// Notes: Wide lines are single long lines inside a frame.
`default_nettype none
module vga_input_mode_scaler_tb_top;
	import vims_pkg::*;
	timeunit 1ns;
	timeprecision 100ps;
	logic MCLK = 0, RST_B = 0, SW = 0, WIDE = 0, go = 0, hpol = 0, vpol = 1;
	logic HS, VS, PV, busy, tick;
	logic [17:0] PD, OUT_DATA, last_d, d8;
	logic [13:0] flen = 14'd3333;
	logic [9:0] npix = 0, PLL_DIV, OUT_COL;
	logic [3:0] nl = 0;
	logic [3:0] llen = 4'd6;
	logic [8:0] OUT_ROW, row0, rowl;
	logic [1:0] OUT_ROW_CNT;
	vims_mode_t MODE;
	logic MODE_LOCK, GFX_ONLY, OUT_VALID;
	int fail_count = 0, checked = 0, n_out = 0, n_ln = 0, n_rc = 0;
	vims_vga_src vims_vga_src_inst (.clk(MCLK), .hpol(hpol), .vpol(vpol), .frame_len(flen),
		.line_len(llen), .npix(npix), .nlines(nl), .go(go), .hsync(HS), .vsync(VS), .pix_valid(PV),
		.pix_data(PD), .busy(busy), .frame_tick(tick));
	vims_top #(.P_CLK_HZ(200000)) vims_top_inst (.MCLK(MCLK), .RST_B(RST_B), .HSYNC(HS),
		.VSYNC(VS), .DISPLAY_MODE_SWITCH(SW), .WIDE_SRC(WIDE), .PIX_VALID(PV),
		.PIX_DATA(PD), .MODE(MODE), .MODE_LOCK(MODE_LOCK), .GFX_ONLY(GFX_ONLY),
		.PLL_DIV(PLL_DIV), .OUT_VALID(OUT_VALID), .OUT_DATA(OUT_DATA), .OUT_COL(OUT_COL),
		.OUT_ROW(OUT_ROW), .OUT_ROW_CNT(OUT_ROW_CNT));
	// ************************
	// Clock, monitor, helpers
	// ************************
	// 200 MHz clock
	initial begin
		forever #2.5 MCLK = ~MCLK;
	end
	// Output pixel monitor
	always @(posedge MCLK) begin
		if (OUT_VALID === 1'b1) begin
			n_out++;
			last_d = OUT_DATA;
			if (OUT_COL === 10'd8) d8 = OUT_DATA;
			if (OUT_COL === 10'd0) begin
				if (n_ln == 0) row0 = OUT_ROW;
				n_rc += int'(OUT_ROW_CNT);
				rowl = OUT_ROW;
				n_ln++;
			end
		end
	end
	task automatic chk(input string nm, input logic [17:0] e, input logic [17:0] g);
		checked++;
		if (g !== e) begin
			fail_count++;
			$display("MISMATCH %s expected %0h seen %0h", nm, e, g);
		end
	endtask : chk
	task automatic frames(input int n);
		repeat (n) begin
			@(posedge MCLK);
			while (tick !== 1'b1) @(posedge MCLK);
		end
		repeat (40) @(posedge MCLK);
	endtask : frames
	task automatic burst(input int np, input int lines);
		n_out = 0;
		n_ln = 0;
		n_rc = 0;
		npix <= 10'(np);
		nl <= 4'(lines);
		go <= 1'b1;
		@(posedge MCLK);
		go <= 1'b0;
		repeat (3) @(posedge MCLK);
		for (int i = 0; i < 2000 && busy === 1'b1; i++) @(posedge MCLK);
		repeat (6) @(posedge MCLK);
	endtask : burst
	task automatic mode_is(input vims_mode_t m, input logic [9:0] div, input logic gfx);
		chk("MODE", 18'(m), 18'(MODE));
		chk("MODE_LOCK", 18'(1), 18'(MODE_LOCK));
		chk("PLL_DIV", 18'(div), 18'(PLL_DIV));
		chk("GFX_ONLY", 18'(gfx), 18'(GFX_ONLY));
	endtask : mode_is
	task automatic tally_and_finish;
		$display("checked %0d fail_count %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : tally_and_finish
	// ************************
	// Scenarios
	// ************************
	task automatic t_reset;
		chk("MODE", 18'(VIMS_NONE), 18'(MODE));
		chk("PLL_DIV", 18'h0, 18'(PLL_DIV));
		chk("OUT_VALID", 18'h0, 18'(OUT_VALID));
	endtask : t_reset
	// Low hsync, high vsync, 60 Hz, narrow lines
	task automatic t_480;
		frames(4);
		mode_is(VIMS_640X480_60, 10'd800, 1'b0);
		burst(700, 1);
		chk("count", 18'd640, 18'(n_out));
		chk("last", 18'd639, last_d);
		frames(1);
		burst(4, 6);
		chk("row0", 18'h0, 18'(row0));
		chk("rows", 18'd5, 18'(rowl - row0));
		chk("rowcnt", 18'd6, 18'(n_rc));
	endtask : t_480
	task automatic t_720_gfx;
		frames(4);
		mode_is(VIMS_720X350_70, 10'd900, 1'b1);
		frames(1);
		burst(4, 6);
		chk("row0", 18'd30, 18'(row0));
		chk("rows", 18'd6, 18'(rowl - row0));
		chk("rowcnt", 18'd7, 18'(n_rc));
		burst(720, 1);
		chk("count", 18'd640, 18'(n_out));
		chk("col8", 18'd9, d8);
		chk("last", 18'd718, last_d);
	endtask : t_720_gfx
	task automatic t_720_text;
		frames(1);
		mode_is(VIMS_720X350_70, 10'd900, 1'b0);
		burst(720, 1);
		chk("count", 18'd640, 18'(n_out));
		chk("col8", 18'd8, d8);
		chk("last", 18'd639, last_d);
	endtask : t_720_text
	// Active-high 70 Hz vertical sync marks 400 lines
	task automatic t_400;
		vpol <= 1'b1;
		frames(4);
		mode_is(VIMS_640X400_70, 10'd800, 1'b0);
		burst(4, 6);
		chk("row0", 18'h0, 18'(row0));
		chk("rows", 18'd6, 18'(rowl - row0));
		chk("rowcnt", 18'd7, 18'(n_rc));
		WIDE <= 1'b1;
		frames(1);
		mode_is(VIMS_720X400_70, 10'd900, 1'b0);
	endtask : t_400
	// Slower lines and 56 Hz frames
	task automatic t_56;
		flen <= 14'd3571;
		llen <= 4'd8;
		WIDE <= 1'b0;
		frames(2);
		mode_is(VIMS_640X400_56, 10'd848, 1'b0);
	endtask : t_56
	// Main sequence, reset held six cycles
	initial begin
		repeat (6) @(posedge MCLK);
		t_reset();
		RST_B <= 1'b1;
		t_480();
		hpol <= 1'b1;
		vpol <= 1'b0;
		flen <= 14'd2857;
		WIDE <= 1'b1;
		SW <= 1'b1;
		t_720_gfx();
		SW <= 1'b0;
		t_720_text();
		WIDE <= 1'b0;
		frames(1);
		mode_is(VIMS_640X350_70, 10'd800, 1'b0);
		t_400();
		t_56();
		tally_and_finish();
	end
	// Hang guard, about a third above the expected run
	initial begin
		repeat (80000) @(posedge MCLK);
		fail_count++;
		tally_and_finish();
	end
endmodule : vga_input_mode_scaler_tb_top
`default_nettype wire
